// ==== subt_pkg.sv ====
package subt_pkg;
  // Widths of the transfer path
  localparam int UNIT_W    = 4;
  localparam int CNT_W     = 8;
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 16;
  localparam int NUM_UNITS = 16;

  // Information word layout: unit digit on top, three count digits below
  localparam int UNIT_MSB = 15;
  localparam int UNIT_LSB = 12;
  localparam int CNT_MSB  = 11;
  localparam int CNT_LSB  = 0;

  // Legal word count, binary value of the BCD field
  localparam logic [9:0] CNT_MIN = 10'h001;
  localparam logic [9:0] CNT_MAX = 10'h080;

  // Handshake watchdog, longest wait rounds down
  localparam int CLK_MHZ        = 200;
  localparam int HS_TIMEOUT_NS  = 10000;
  localparam int HS_TIMEOUT_CYC = HS_TIMEOUT_NS * CLK_MHZ / 1000;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_RDW,
    ST_FETCH,
    ST_LOAD,
    ST_SEND,
    ST_ENDW
  } subt_state_e;
endpackage : subt_pkg

// ==== subt_info_check.sv ====
`timescale 1ns/100ps
module subt_info_check (
  input  logic [15:0]                  info_word,
  input  logic [15:0]                  ptr_word,
  output logic [subt_pkg::UNIT_W-1:0]  unit,
  output logic [subt_pkg::CNT_W-1:0]   cnt_bin,
  output logic                         cnt_ok,
  output logic                         ptr_ok,
  output logic [subt_pkg::ADDR_W-1:0]  ptr_bin
);

  // One BCD digit is legal
  function automatic logic dig_ok(input logic [3:0] d);
    dig_ok = (d <= 4'h9);
  endfunction : dig_ok

  // Binary value of a four digit BCD word
  function automatic logic [13:0] bcd_val(input logic [15:0] w);
    bcd_val = 14'({10'h000, w[15:12]}) * 14'h03E8
            + 14'({10'h000, w[11:8]}) * 14'h0064
            + 14'({10'h000, w[7:4]}) * 14'h000A
            + 14'({10'h000, w[3:0]});
  endfunction : bcd_val

  logic [13:0] cnt_val;

  // Unit from top digit, count from the lower three
  assign unit    = info_word[subt_pkg::UNIT_MSB:subt_pkg::UNIT_LSB];
  assign cnt_val = bcd_val({4'h0, info_word[subt_pkg::CNT_MSB:0]});
  assign cnt_bin = cnt_val[subt_pkg::CNT_W-1:0];

  // Count must be BCD and 001..128
  assign cnt_ok = dig_ok(info_word[11:8]) && dig_ok(info_word[7:4])
                && dig_ok(info_word[3:0])
                && (cnt_val[9:0] >= subt_pkg::CNT_MIN)
                && (cnt_val <= 14'({4'h0, subt_pkg::CNT_MAX}));

  // Indirect pointer must be all BCD
  assign ptr_ok  = dig_ok(ptr_word[15:12]) && dig_ok(ptr_word[11:8])
                 && dig_ok(ptr_word[7:4]) && dig_ok(ptr_word[3:0]);
  assign ptr_bin = bcd_val(ptr_word);
endmodule : subt_info_check

// ==== subt_top.sv ====
`timescale 1ns/100ps
// Functional notes
// - Transfer runs only when the instruction executes with condition on.
// - Information word supplies both target unit and word count.
// - Word count must be BCD 001 through 128.
// - Units on a slave rack are rejected with the error flag.
// - Bad count on write or read sets the error flag.
// - Unit number beyond the installed unit range sets the error flag.
// - Non-BCD indirect pointer or pointer past area end sets error.
// - Unit lacking read or write capability sets the error flag.
// - Unit internal or verification fault sets the error flag.
// - Any handshake failure ends with the error flag set.
// - Transfer running past the controller area end sets error.
// - Unit reporting word range exceeded on write sets error.
// - After read, equality high only when all data arrived.
// - After write, equality high only when all data was delivered.
// - Write to disabled unit handshakes, then clears equality and error.
// - Count and unit checked at execution; errors move no data.
// - Interrupt write to scan-refreshed unit raises conflict and error.
// - Unreceived write clears equality and error, sets reception flag.
module subt_top #(
  parameter int NUM_UNITS  = subt_pkg::NUM_UNITS,
  parameter int HS_TIMEOUT = subt_pkg::HS_TIMEOUT_CYC
) (
  input  logic                          clk,
  input  logic                          arst_n,
  input  logic                          instr_exec,
  input  logic                          exec_cond,
  input  logic                          instr_write,
  input  logic [15:0]                   info_word,
  input  logic [15:0]                   ctrl_code,
  input  logic [subt_pkg::ADDR_W-1:0]   first_word,
  input  logic [subt_pkg::ADDR_W-1:0]   area_last,
  input  logic                          ptr_used,
  input  logic [15:0]                   ptr_word,
  input  logic                          hs_irq_mode,
  input  logic                          in_irq_prog,
  input  logic [NUM_UNITS-1:0]          unit_on_slave,
  input  logic [NUM_UNITS-1:0]          unit_rd_cap,
  input  logic [NUM_UNITS-1:0]          unit_wr_cap,
  input  logic [NUM_UNITS-1:0]          unit_exec_en,
  input  logic [NUM_UNITS-1:0]          unit_scan_rfsh,
  output logic [subt_pkg::ADDR_W-1:0]   mem_addr,
  output logic                          mem_we,
  output logic                          mem_re,
  output logic [subt_pkg::DATA_W-1:0]   mem_wdata,
  input  logic [subt_pkg::DATA_W-1:0]   mem_rdata,
  output logic                          io_req,
  output logic [subt_pkg::UNIT_W-1:0]   io_unit,
  output logic                          io_write,
  output logic [15:0]                   io_ctrl,
  output logic [subt_pkg::CNT_W-1:0]    io_count,
  input  logic                          io_ack,
  input  logic                          io_nak,
  input  logic                          io_range_err,
  output logic                          io_rready,
  input  logic                          io_rvalid,
  input  logic [subt_pkg::DATA_W-1:0]   io_rdata,
  output logic                          io_wvalid,
  output logic [subt_pkg::DATA_W-1:0]   io_wdata,
  input  logic                          io_wready,
  input  logic                          io_done,
  input  logic                          io_rx_ok,
  input  logic                          io_unit_err,
  output logic                          busy,
  output logic                          done,
  output logic                          error_flag,
  output logic                          equality_flag,
  output logic                          interrupt_write_conflict_flag,
  output logic                          reception_error_flag
);

  localparam int AW1 = subt_pkg::ADDR_W + 1;
  localparam int TW  = $clog2(HS_TIMEOUT + 1);

  subt_pkg::subt_state_e              st_reg;
  subt_pkg::subt_state_e              st_next;
  logic [subt_pkg::UNIT_W-1:0]        unit_reg;
  logic                               write_reg;
  logic [15:0]                        ctrl_reg;
  logic [subt_pkg::CNT_W-1:0]         count_reg;
  logic [subt_pkg::CNT_W-1:0]         left_reg;
  logic [subt_pkg::ADDR_W-1:0]        addr_reg;
  logic [TW-1:0]                      tmo_cnt_reg;
  logic                               mem_we_reg;
  logic                               mem_re_reg;
  logic [subt_pkg::DATA_W-1:0]        mem_wdata_reg;
  logic                               io_req_reg;
  logic                               io_rready_reg;
  logic                               io_wvalid_reg;
  logic [subt_pkg::DATA_W-1:0]        io_wdata_reg;
  logic                               busy_reg;
  logic                               done_reg;
  logic                               er_reg;
  logic                               eq_reg;
  logic                               cf_reg;
  logic                               rx_reg;
  logic [subt_pkg::UNIT_W-1:0]        chk_unit;
  logic [subt_pkg::CNT_W-1:0]         chk_cnt;
  logic                               cnt_ok;
  logic                               ptr_ok;
  logic [subt_pkg::ADDR_W-1:0]        ptr_bin;
  logic [subt_pkg::ADDR_W-1:0]        first_sel;
  logic [AW1-1:0]                     last_addr;
  logic                               unit_ok;
  logic                               slave_err;
  logic                               cap_err;
  logic                               ptr_err;
  logic                               ovf_err;
  logic                               conflict;
  logic                               chk_err;
  logic                               start;
  logic                               waiting;
  logic                               tmo;
  logic                               fin;
  logic                               fin_er;
  logic                               fin_eq;
  logic                               fin_rx;
  logic                               fin_cf;
  logic                               word_step;

  // Field extraction and BCD checks
  subt_info_check u_check (
    .info_word (info_word),
    .ptr_word  (ptr_word),
    .unit      (chk_unit),
    .cnt_bin   (chk_cnt),
    .cnt_ok    (cnt_ok),
    .ptr_ok    (ptr_ok),
    .ptr_bin   (ptr_bin)
  );

  // Execution-time checks, all before any handshake
  assign start     = instr_exec && exec_cond && !busy_reg;
  assign unit_ok   = int'(chk_unit) < NUM_UNITS;
  assign slave_err = unit_ok && unit_on_slave[chk_unit];
  assign cap_err   = unit_ok && (instr_write ? !unit_wr_cap[chk_unit]
                                             : !unit_rd_cap[chk_unit]);
  assign first_sel = ptr_used ? ptr_bin : first_word;
  assign ptr_err   = ptr_used && (!ptr_ok || ptr_bin > area_last);
  assign last_addr = AW1'(first_sel) + AW1'(chk_cnt) - AW1'(1);
  assign ovf_err   = last_addr > AW1'(area_last);
  assign conflict  = instr_write && hs_irq_mode && in_irq_prog && unit_ok
                     && unit_scan_rfsh[chk_unit];
  assign chk_err   = !cnt_ok || !unit_ok || slave_err || cap_err
                     || ptr_err || (cnt_ok && ovf_err) || conflict;

  // Handshake watchdog only runs in states that wait on the unit
  assign waiting = (st_reg == subt_pkg::ST_REQ)
                || (st_reg == subt_pkg::ST_RDW)
                || (st_reg == subt_pkg::ST_SEND)
                || (st_reg == subt_pkg::ST_ENDW);
  assign tmo     = waiting && (tmo_cnt_reg == TW'(HS_TIMEOUT - 1));

  // Sequencer decisions and final flag values
  always_comb
  begin
    st_next   = st_reg;
    fin       = 1'b0;
    fin_er    = 1'b0;
    fin_eq    = 1'b0;
    fin_rx    = 1'b0;
    fin_cf    = 1'b0;
    word_step = 1'b0;
    if (st_reg != subt_pkg::ST_IDLE && (io_unit_err || tmo))
    begin
      fin    = 1'b1;
      fin_er = 1'b1;
    end
    else
    begin
      case (st_reg)
        subt_pkg::ST_IDLE:
          if (start)
          begin
            if (chk_err)
            begin
              fin    = 1'b1;
              fin_er = 1'b1;
              fin_cf = conflict;
            end
            else
              st_next = subt_pkg::ST_REQ;
          end
        subt_pkg::ST_REQ:
          if (io_nak)
          begin
            fin    = 1'b1;
            fin_er = 1'b1;
          end
          else if (io_ack)
          begin
            if (write_reg && !unit_exec_en[unit_reg])
              fin = 1'b1;
            else if (write_reg && io_range_err)
            begin
              fin    = 1'b1;
              fin_er = 1'b1;
            end
            else if (write_reg)
              st_next = subt_pkg::ST_FETCH;
            else
              st_next = subt_pkg::ST_RDW;
          end
        subt_pkg::ST_RDW:
          if (io_rvalid)
          begin
            word_step = 1'b1;
            if (left_reg == subt_pkg::CNT_W'(1))
              st_next = subt_pkg::ST_ENDW;
          end
        subt_pkg::ST_FETCH:
          st_next = subt_pkg::ST_LOAD;
        subt_pkg::ST_LOAD:
          st_next = subt_pkg::ST_SEND;
        subt_pkg::ST_SEND:
          if (io_wready)
          begin
            word_step = 1'b1;
            st_next   = (left_reg == subt_pkg::CNT_W'(1))
                        ? subt_pkg::ST_ENDW : subt_pkg::ST_FETCH;
          end
        subt_pkg::ST_ENDW:
          if (io_done)
          begin
            fin = 1'b1;
            if (write_reg && !io_rx_ok)
              fin_rx = 1'b1;
            else
              fin_eq = 1'b1;
          end
        default:
          fin = 1'b1;
      endcase
    end
    if (fin)
      st_next = subt_pkg::ST_IDLE;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= subt_pkg::ST_IDLE;
    else
      st_reg <= st_next;
  end

  // Latch the accepted instruction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unit_reg  <= '0;
      write_reg <= 1'b0;
      ctrl_reg  <= '0;
      count_reg <= '0;
    end
    else if (start && !chk_err)
    begin
      unit_reg  <= chk_unit;
      write_reg <= instr_write;
      ctrl_reg  <= ctrl_code;
      count_reg <= chk_cnt;
    end
  end

  // Word counter and controller address walk
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left_reg <= '0;
      addr_reg <= '0;
    end
    else if (start && !chk_err)
    begin
      left_reg <= chk_cnt;
      addr_reg <= first_sel;
    end
    else
    begin
      if (word_step)
        left_reg <= left_reg - subt_pkg::CNT_W'(1);
      if (mem_we_reg || (word_step && write_reg))
        addr_reg <= addr_reg + subt_pkg::ADDR_W'(1);
    end
  end

  // Watchdog restarts on every sign of progress
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tmo_cnt_reg <= '0;
    else if (st_next != st_reg || word_step || fin || !waiting)
      tmo_cnt_reg <= '0;
    else
      tmo_cnt_reg <= tmo_cnt_reg + TW'(1);
  end

  // Controller memory side strobes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_we_reg    <= 1'b0;
      mem_re_reg    <= 1'b0;
      mem_wdata_reg <= '0;
    end
    else
    begin
      mem_we_reg <= word_step && !write_reg;
      mem_re_reg <= (st_next == subt_pkg::ST_FETCH);
      if (word_step && !write_reg)
        mem_wdata_reg <= io_rdata;
    end
  end

  // Unit side handshake outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_req_reg    <= 1'b0;
      io_rready_reg <= 1'b0;
      io_wvalid_reg <= 1'b0;
      io_wdata_reg  <= '0;
    end
    else
    begin
      io_req_reg    <= (st_next == subt_pkg::ST_REQ);
      io_rready_reg <= (st_next == subt_pkg::ST_RDW);
      io_wvalid_reg <= (st_next == subt_pkg::ST_SEND);
      if (st_reg == subt_pkg::ST_LOAD)
        io_wdata_reg <= mem_rdata;
    end
  end

  // Busy and completion
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= (st_next != subt_pkg::ST_IDLE);
      done_reg <= fin;
    end
  end

  // Result flags, rewritten at the end of every instruction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      er_reg <= 1'b0;
      eq_reg <= 1'b0;
      cf_reg <= 1'b0;
      rx_reg <= 1'b0;
    end
    else if (fin)
    begin
      er_reg <= fin_er;
      eq_reg <= fin_eq;
      cf_reg <= fin_cf;
      rx_reg <= fin_rx;
    end
  end

  assign mem_addr                      = addr_reg;
  assign mem_we                        = mem_we_reg;
  assign mem_re                        = mem_re_reg;
  assign mem_wdata                     = mem_wdata_reg;
  assign io_req                        = io_req_reg;
  assign io_unit                       = unit_reg;
  assign io_write                      = write_reg;
  assign io_ctrl                       = ctrl_reg;
  assign io_count                      = count_reg;
  assign io_rready                     = io_rready_reg;
  assign io_wvalid                     = io_wvalid_reg;
  assign io_wdata                      = io_wdata_reg;
  assign busy                          = busy_reg;
  assign done                          = done_reg;
  assign error_flag                    = er_reg;
  assign equality_flag                 = eq_reg;
  assign interrupt_write_conflict_flag = cf_reg;
  assign reception_error_flag          = rx_reg;

  // Condition off: nothing starts
  AST_COND_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    instr_exec && !exec_cond && !busy_reg |=> !busy_reg && !done_reg)
    else $error("transfer started with condition off");

  // Bad count: error, no equality, no request
  AST_BAD_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
    start && !cnt_ok |=> done_reg && error_flag && !equality_flag
                        && !io_req_reg)
    else $error("bad count not rejected");

  // Slave rack unit rejected
  AST_SLAVE: assert property (@(posedge clk) disable iff (!arst_n)
    start && slave_err |=> error_flag && !busy_reg)
    else $error("slave rack unit accepted");

  // Bad pointer rejected
  AST_POINTER: assert property (@(posedge clk) disable iff (!arst_n)
    start && ptr_err |=> error_flag && done_reg)
    else $error("bad pointer accepted");

  // Missing capability rejected
  AST_CAP: assert property (@(posedge clk) disable iff (!arst_n)
    start && cap_err |=> error_flag)
    else $error("incapable unit accepted");

  // Rejected instruction moves no data for two cycles
  AST_NO_DATA: assert property (@(posedge clk) disable iff (!arst_n)
    start && chk_err |=> (!io_req_reg && !mem_we_reg && !mem_re_reg)[*2])
    else $error("data moved after failed check");

  // Unit fault ends the transfer with error
  AST_UNIT_ERR: assert property (@(posedge clk) disable iff (!arst_n)
    busy_reg && io_unit_err |=> error_flag && done_reg && !busy_reg)
    else $error("unit fault not reported");

  // Refused handshake ends with error
  AST_NAK: assert property (@(posedge clk) disable iff (!arst_n)
    io_req_reg && io_nak && !io_unit_err |=> error_flag && !io_req_reg)
    else $error("handshake refusal not reported");

  // Overflowing area rejected
  AST_OVF: assert property (@(posedge clk) disable iff (!arst_n)
    start && cnt_ok && ovf_err |=> error_flag && !equality_flag)
    else $error("area overflow accepted");

  // Disabled unit: both flags clear, no error
  AST_DISABLED: assert property (@(posedge clk) disable iff (!arst_n)
    io_req_reg && io_ack && write_reg && !unit_exec_en[unit_reg]
    && !io_unit_err && !tmo
    |=> done_reg && !error_flag && !equality_flag && !io_wvalid_reg)
    else $error("disabled unit handled wrongly");

  // Clean completion gives equality
  AST_EQ: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg == subt_pkg::ST_ENDW && io_done && !io_unit_err && !tmo
    && (!write_reg || io_rx_ok)
    |=> equality_flag && !error_flag && !reception_error_flag)
    else $error("equality not set on success");

  // Unreceived write sets reception flag only
  AST_RX: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg == subt_pkg::ST_ENDW && io_done && write_reg && !io_rx_ok
    && !io_unit_err && !tmo
    |=> reception_error_flag && !error_flag && !equality_flag)
    else $error("reception error handled wrongly");

  // Interrupt conflict raises both flags
  AST_CONFLICT: assert property (@(posedge clk) disable iff (!arst_n)
    start && conflict |=> interrupt_write_conflict_flag && error_flag)
    else $error("interrupt write conflict missed");

  // Busy covers every handshake cycle
  AST_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
    io_req_reg || io_rready_reg || io_wvalid_reg |-> busy_reg && !done_reg)
    else $error("handshake outside busy");
endmodule : subt_top

// ==== subt_unit_model.sv ====
`timescale 1ns/100ps
module subt_unit_model (
  input  logic        clk,
  input  logic        arst_n,
  input  logic        slow,
  input  logic        nak_inj,
  input  logic        rng_inj,
  input  logic        rx_fail,
  input  logic        err_inj,
  input  logic        io_req,
  input  logic        io_write,
  input  logic [7:0]  io_count,
  input  logic        io_rready,
  input  logic        io_wvalid,
  output logic        io_ack,
  output logic        io_nak,
  output logic        io_range_err,
  output logic        io_rvalid,
  output logic [15:0] io_rdata,
  output logic        io_wready,
  output logic        io_done,
  output logic        io_rx_ok,
  output logic        io_unit_err
);
  logic [7:0]  left_reg;
  logic [15:0] last_reg;
  logic        act_reg;
  logic        tick_reg;
  logic        hit;

  // Control code is never looked at here
  assign hit = io_req && !io_ack && !io_nak;
  // Answer requests, count words, end the transfer
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {io_ack, io_nak, io_range_err, io_done, io_rx_ok} <= 5'h00;
      {act_reg, tick_reg, left_reg, last_reg} <= 26'h0000000;
    end
    else
    begin
      io_ack       <= hit && !nak_inj;
      io_nak       <= hit && nak_inj;
      io_range_err <= hit && rng_inj;
      tick_reg     <= !tick_reg || !slow;
      io_done      <= act_reg && left_reg == 8'h00;
      io_rx_ok     <= !rx_fail;
      if (act_reg && left_reg == 8'h00)
        act_reg <= 1'b0;
      if (hit)
      begin
        act_reg  <= !nak_inj;
        left_reg <= io_count;
      end
      else if ((io_rvalid && io_rready) || (io_wvalid && io_wready))
      begin
        left_reg <= left_reg - 8'h01;
        last_reg <= io_rdata;
      end
    end
  // Words offered; released data line flips
  assign io_rvalid = act_reg && !io_write && left_reg != 0 && tick_reg;
  assign io_rdata  = io_rvalid ? 16'hA000 + 16'(io_count - left_reg)
                               : ~last_reg;
  assign io_wready = act_reg && io_write && left_reg != 0 && tick_reg;
  assign io_unit_err = act_reg && err_inj;
endmodule : subt_unit_model

// ==== subt_top_tb.sv ====
`timescale 1ns/100ps
module subt_top_tb;
  localparam int U = 12;
  logic clk, arst_n, instr_exec, exec_cond, instr_write, ptr_used;
  logic hs_irq_mode, in_irq_prog, mem_we, mem_re, io_req, io_write;
  logic io_ack, io_nak, io_range_err, io_rready, io_rvalid, io_wvalid;
  logic io_wready, io_done, io_rx_ok, io_unit_err, busy, done;
  logic error_flag, equality_flag;
  logic interrupt_write_conflict_flag, reception_error_flag;
  logic slow, nak_inj, rng_inj, rx_fail, err_inj;
  logic [15:0] info_word, ctrl_code, ptr_word, mem_wdata, mem_rdata;
  logic [15:0] io_ctrl, io_rdata, io_wdata;
  logic [13:0] first_word, area_last, mem_addr;
  logic [U-1:0] unit_on_slave, unit_rd_cap, unit_wr_cap;
  logic [U-1:0] unit_exec_en, unit_scan_rfsh;
  logic [3:0] io_unit;
  logic [7:0] io_count;
  logic [31:0] exp_q[$];
  int fail_count, samples_checked, seed, n, k;

  subt_top #(.NUM_UNITS(U), .HS_TIMEOUT(16)) dut_u (.*);
  subt_unit_model unit_u (.*);

  task automatic chk_bit(input logic got, input logic exp, input string s);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %b", $time, s, got);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  function automatic logic [15:0] bcd(input int u, input int c);
    return {4'(u), 4'(c / 100), 4'((c / 10) % 10), 4'(c % 10)};
  endfunction : bcd

  // Flags expected as {error, equality, reception, conflict}
  task automatic run(input logic w, input logic [15:0] info, input int base,
                     input int cnt, input logic [3:0] fl);
    for (int i = 0; i < cnt; i++)
      exp_q.push_back({16'(base + i), w ? 16'h5000 + 16'(base + i)
                                        : 16'hA000 + 16'(i)});
    instr_write = w;
    info_word   = info;
    first_word  = ptr_used ? 14'h0000 : 14'(base);
    ctrl_code   = 16'($random(seed));
    instr_exec  = 1'b1;
    @(posedge clk);
    #1 instr_exec = 1'b0;
    if (cnt > 0) chk_bit(busy, 1'b1, "busy");
    for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge clk) #1;
    chk_bit(done, 1'b1, "done");
    chk_bit(error_flag, fl[3], "er");
    chk_bit(equality_flag, fl[2], "eq");
    chk_bit(reception_error_flag, fl[1], "rx");
    chk_bit(interrupt_write_conflict_flag, fl[0], "cf");
    chk_bit(exp_q.size() == 0, 1'b1, "count");
    if (fl[2]) chk_word(16'(io_unit), 16'(info[15:12]));
    if (fl[2]) chk_word(16'(io_count), 16'(cnt));
    if (fl[2]) chk_word(io_ctrl, ctrl_code);
    exp_q.delete();
    @(posedge clk) #1;
  endtask : run

  // Controller memory answers the cycle after a read strobe
  always @(posedge clk)
    mem_rdata <= mem_re ? 16'h5000 + {2'h0, mem_addr} : ~mem_rdata;

  // Every moved word checked against the expected queue
  always @(negedge clk)
    if (mem_we || (io_wvalid && io_wready))
    begin
      chk_bit(exp_q.size() != 0, 1'b1, "extra");
      if (exp_q.size() != 0)
      begin
        if (mem_we) chk_word({2'h0, mem_addr}, exp_q[0][31:16]);
        chk_word(mem_we ? mem_wdata : io_wdata, exp_q[0][15:0]);
        void'(exp_q.pop_front());
      end
    end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    {fail_count, samples_checked, seed} = {32'h0, 32'h0, 32'hB3C7};
    {arst_n, instr_exec, instr_write, ptr_used, hs_irq_mode} = 5'h00;
    {in_irq_prog, slow, nak_inj, rng_inj, rx_fail, err_inj} = 6'h00;
    {exec_cond, info_word, ptr_word, mem_rdata} = {1'b1, 48'h0};
    {first_word, area_last} = {14'h0000, 14'h3FFF};
    {unit_on_slave, unit_scan_rfsh} = '0;
    {unit_rd_cap, unit_wr_cap, unit_exec_en} = '1;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    run(0, bcd(3, 2), 256, 2, 4'h4);
    n = 1 + ($unsigned($random(seed)) % 128);
    slow = 1'b1;
    run(0, bcd(5, n), 512, n, 4'h4);
    slow = 1'b0;
    run(1, bcd(2, 1), 64, 1, 4'h4);
    run(1, bcd(11, 128), 1000, 128, 4'h4);
    run(0, bcd(3, 0), 9, 0, 4'h8);
    run(1, bcd(3, 129), 9, 0, 4'h8);
    run(0, 16'h30A1, 9, 0, 4'h8);
    run(0, bcd(13, 1), 9, 0, 4'h8);
    unit_on_slave[4] = 1'b1;
    run(0, bcd(4, 1), 9, 0, 4'h8);
    {unit_rd_cap[6], unit_wr_cap[7]} = 2'b00;
    run(0, bcd(6, 1), 9, 0, 4'h8);
    run(1, bcd(7, 1), 9, 0, 4'h8);
    err_inj = 1'b1;
    run(1, bcd(1, 4), 9, 0, 4'h8);
    {err_inj, nak_inj} = 2'b01;
    run(0, bcd(1, 4), 9, 0, 4'h8);
    {nak_inj, rng_inj, area_last} = {2'b01, 14'h0FFF};
    run(1, bcd(2, 3), 9, 0, 4'h8);
    rng_inj = 1'b0;
    run(0, bcd(2, 3), 4094, 0, 4'h8);
    run(0, bcd(2, 3), 4093, 3, 4'h4);
    unit_exec_en[2] = 1'b0;
    run(1, bcd(2, 2), 9, 0, 4'h0);
    rx_fail = 1'b1;
    run(1, bcd(1, 2), 9, 2, 4'h2);
    {rx_fail, hs_irq_mode, in_irq_prog, unit_scan_rfsh[8]} = 4'h7;
    run(1, bcd(8, 1), 9, 0, 4'h9);
    {ptr_used, ptr_word} = {1'b1, 16'h0123};
    run(0, bcd(1, 1), 123, 1, 4'h4);
    ptr_word = 16'h01A3;
    run(0, bcd(1, 1), 9, 0, 4'h8);
    {ptr_used, exec_cond, instr_exec} = 3'b001;
    repeat (20) @(posedge clk) #1 instr_exec = 1'b0;
    chk_bit(busy | done, 1'b0, "idle");
    tally_and_finish();
  end
endmodule : subt_top_tb
